/* src/ccr_pkg.sv */
// Function
// - Eight composites; index bits pick method factors
// - Six independent 3-bit destination selectors
// - Selectors packed into three 8-bit registers
// - Destinations: aux loop, converters, oscillators, channels
// - Nonzero selection tracks composite continuously
// - Slew limiter caps composite rate of change
// - Slew code: none, 0.715 doubling to 45.76
// - One slew setting for composites one-seven
// - Oscillator 0 selector at 0x281 bits 2:0
// - Method three factor frozen during holdover
package ccr_pkg;

  // ---------------------------------------------------------------
  // Clock and factor format
  // ---------------------------------------------------------------
  localparam longint CLK_HZ      = 100_000_000;
  localparam int     FW          = 32;
  // Unsigned factors, 2 integer and 30 fraction bits
  localparam int     FRAC        = 30;
  localparam logic [31:0] FACTOR_ONE = 32'h4000_0000;

  // ---------------------------------------------------------------
  // Slew limit timing
  // ---------------------------------------------------------------
  // Slowest limit, 0.715 ppm/s, expressed in ppb/s
  localparam longint SLEW_UNIT_PPB = 715;
  // Cycles per factor LSB at the slowest limit
  localparam longint SLEW_TICK_CYC =
    (CLK_HZ * 64'd1_000_000_000) / (SLEW_UNIT_PPB * (64'd1 << FRAC));

  // ---------------------------------------------------------------
  // Register map (indices; byte address is four times the index)
  // ---------------------------------------------------------------
  localparam int          AW           = 12;
  localparam logic [9:0]  IDX_SEL_AUX  = 10'h280;
  localparam logic [9:0]  IDX_SEL_OSC  = 10'h281;
  localparam logic [9:0]  IDX_SEL_LOOP = 10'h282;
  localparam logic [9:0]  IDX_SLEW     = 10'h283;
  localparam logic [9:0]  IDX_STATUS   = 10'h287;

  // Selector fields: low destination bits 2:0, high bits 6:4
  localparam int          SEL_W        = 3;
  localparam int          SEL_LO_LSB   = 0;
  localparam int          SEL_HI_LSB   = 4;
  localparam logic [7:0]  SEL_MASK     = 8'h77;
  localparam logic [7:0]  SEL_RESET    = 8'h00;
  localparam int          SLEW_LSB     = 0;
  localparam logic [2:0]  SLEW_RESET   = 3'h0;
  // Status bits
  localparam int          ST_HOLD_BIT  = 0;
  localparam int          ST_SLEW_BIT  = 1;

  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // ---------------------------------------------------------------
  // Destinations
  // ---------------------------------------------------------------
  localparam int          NDEST        = 6;
  localparam int          NCOMP        = 8;

  typedef struct packed {
    logic [31:0] method_one_factor;
    logic [31:0] method_two_factor;
    logic [31:0] method_three_factor;
  } ccr_factors_type;

  typedef struct packed {
    logic [31:0] aux_loop;
    logic [31:0] converters;
    logic [31:0] aux_osc0;
    logic [31:0] aux_osc1;
    logic [31:0] main_loop_channel_0;
    logic [31:0] main_loop_channel_1;
  } ccr_dest_type;

endpackage

/* src/ccr_slew.sv */
`timescale 1ns/1ps
`default_nettype none
module ccr_slew
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Control
  input  wire logic [31:0] target,
  input  wire logic [31:0] step,
  input  wire logic        tick,
  // Result
  output logic      [31:0] value_r
);

  logic [31:0] value_nxt;
  logic [31:0] diff;

  // ---------------------------------------------------------------
  // Move toward target by at most one step per tick; a zero step follows target at once
  // ---------------------------------------------------------------
  always_comb
  begin
    value_nxt = value_r;
    diff      = (target >= value_r) ? target - value_r : value_r - target;
    if (step == 32'h0)
      value_nxt = target;
    else if (tick)
    begin
      if (diff <= step)
        value_nxt = target;
      else if (target > value_r)
        value_nxt = value_r + step;
      else
        value_nxt = value_r - step;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      value_r <= 32'h0;
    else
      value_r <= value_nxt;
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  AST_SLEW_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    (step != 32'h0 && !tick) |=> $stable(value_r))
    else $error("limited value moved without a tick");

  AST_SLEW_STEP: assert property (@(posedge aclk) disable iff (!aresetn)
    (step != 32'h0) |=> ((value_r >= $past(value_r)) ?
      (value_r - $past(value_r)) <= $past(step) :
      ($past(value_r) - value_r) <= $past(step)))
    else $error("limited value jumped more than one step");

endmodule // ccr_slew
`default_nettype wire

/* src/ccr_router.sv */
`timescale 1ns/1ps
`default_nettype none
module ccr_router
#(
  parameter longint SLEW_TICK = ccr_pkg::SLEW_TICK_CYC
)
(
  // Clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // AXI4-Lite write address and data
  input  wire logic [11:0]            s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  // AXI4-Lite read
  input  wire logic [11:0]            s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // Method factors and aux loop state
  input  wire ccr_pkg::ccr_factors_type factors,
  input  wire logic                   aux_holdover,
  // Compensation to destinations
  output ccr_pkg::ccr_dest_type       dest_r
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [7:0]  sel_reg_r [0:2];
  logic [7:0]  sel_reg_nxt [0:2];
  logic [2:0]  slew_r, slew_nxt;
  logic [31:0] f1_r, f2_r, f3_r;
  logic [31:0] f1_nxt, f2_nxt, f3_nxt;
  logic [16:0] tick_cnt_r, tick_cnt_nxt;
  logic        tick;
  logic [31:0] step;
  logic [31:0] target [0:7];
  logic [31:0] limited [0:7];
  logic [2:0]  sel [0:5];
  ccr_pkg::ccr_dest_type dest_nxt;

  logic        aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
  logic [9:0]  wr_idx_r, wr_idx_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic        wstrb0_r, wstrb0_nxt;
  logic        awready_nxt, wready_nxt, bvalid_nxt, arready_nxt;
  logic        rvalid_nxt;
  logic [1:0]  bresp_nxt, rresp_nxt;
  logic [31:0] rdata_nxt;
  logic        wr_en;
  logic [9:0]  rd_idx;

  localparam logic [16:0] TICK_LAST = 17'(SLEW_TICK - 1);

  function automatic logic [31:0] fmul(input logic [31:0] a,
                                       input logic [31:0] b);
    logic [63:0] p;
    p = {32'h0, a} * {32'h0, b};
    return p[ccr_pkg::FRAC +: 32];
  endfunction

  // ---------------------------------------------------------------
  // Method factors; method three freezes in holdover
  // ---------------------------------------------------------------
  always_comb
  begin
    f1_nxt = factors.method_one_factor;
    f2_nxt = factors.method_two_factor;
    f3_nxt = aux_holdover ? f3_r : factors.method_three_factor;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      f1_r <= ccr_pkg::FACTOR_ONE;
      f2_r <= ccr_pkg::FACTOR_ONE;
      f3_r <= ccr_pkg::FACTOR_ONE;
    end
    else
    begin
      f1_r <= f1_nxt;
      f2_r <= f2_nxt;
      f3_r <= f3_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Combiner: index bits select methods, index 0 is zero
  // ---------------------------------------------------------------
  always_comb
  begin
    target[0] = 32'h0;
    for (int k = 1; k < ccr_pkg::NCOMP; k++)
    begin
      target[k] = ccr_pkg::FACTOR_ONE;
      if (k[0])
        target[k] = fmul(target[k], f1_r);
      if (k[1])
        target[k] = fmul(target[k], f2_r);
      if (k[2])
        target[k] = fmul(target[k], f3_r);
    end
  end

  // ---------------------------------------------------------------
  // Global slew limiter for composites 1 to 7
  // ---------------------------------------------------------------
  always_comb
  begin
    tick_cnt_nxt = (tick_cnt_r == TICK_LAST) ? 17'h0 : tick_cnt_r + 17'h1;
    tick         = (tick_cnt_r == TICK_LAST);
    // From code 2 up, each code doubles the step of the previous one
    step         = (slew_r == 3'h0) ? 32'h0 :
                   32'h1 << (slew_r - 3'h1);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tick_cnt_r <= 17'h0;
    else
      tick_cnt_r <= tick_cnt_nxt;
  end

  assign limited[0] = 32'h0;

  generate
    for (genvar k = 1; k < ccr_pkg::NCOMP; k++)
    begin : g_lim
      ccr_slew u_slew
      (
        .aclk    (aclk),
        .aresetn (aresetn),
        .target  (target[k]),
        .step    (step),
        .tick    (tick),
        .value_r (limited[k])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Distributor: six selectors in three registers
  // ---------------------------------------------------------------
  always_comb
  begin
    for (int d = 0; d < ccr_pkg::NDEST; d++)
      sel[d] = sel_reg_r[d / 2][(d % 2) * ccr_pkg::SEL_HI_LSB +: 3];
    dest_nxt.aux_loop            = limited[sel[0]];
    dest_nxt.converters          = limited[sel[1]];
    dest_nxt.aux_osc0            = limited[sel[2]];
    dest_nxt.aux_osc1            = limited[sel[3]];
    dest_nxt.main_loop_channel_0 = limited[sel[4]];
    dest_nxt.main_loop_channel_1 = limited[sel[5]];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      dest_r <= '0;
    else
      dest_r <= dest_nxt;
  end

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  always_comb
  begin
    aw_held_nxt = aw_held_r;
    w_held_nxt  = w_held_r;
    wr_idx_nxt  = wr_idx_r;
    wdata_nxt   = wdata_r;
    wstrb0_nxt  = wstrb0_r;
    bvalid_nxt  = s_axi_bvalid;
    bresp_nxt   = s_axi_bresp;
    for (int r = 0; r < 3; r++)
      sel_reg_nxt[r] = sel_reg_r[r];
    slew_nxt    = slew_r;
    wr_en       = aw_held_r && w_held_r && !s_axi_bvalid;
    if (s_axi_bvalid && s_axi_bready)
      bvalid_nxt = 1'b0;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_nxt = 1'b1;
      wr_idx_nxt  = s_axi_awaddr[11:2];
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_nxt  = 1'b1;
      wdata_nxt   = s_axi_wdata;
      wstrb0_nxt  = s_axi_wstrb[0];
    end
    if (wr_en)
    begin
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = ccr_pkg::RESP_OKAY;
      if (wr_idx_r == ccr_pkg::IDX_SEL_AUX)
      begin
        if (wstrb0_r)
          sel_reg_nxt[0] = wdata_r[7:0] & ccr_pkg::SEL_MASK;
      end
      else if (wr_idx_r == ccr_pkg::IDX_SEL_OSC)
      begin
        if (wstrb0_r)
          sel_reg_nxt[1] = wdata_r[7:0] & ccr_pkg::SEL_MASK;
      end
      else if (wr_idx_r == ccr_pkg::IDX_SEL_LOOP)
      begin
        if (wstrb0_r)
          sel_reg_nxt[2] = wdata_r[7:0] & ccr_pkg::SEL_MASK;
      end
      else if (wr_idx_r == ccr_pkg::IDX_SLEW)
      begin
        if (wstrb0_r)
          slew_nxt = wdata_r[ccr_pkg::SLEW_LSB +: 3];
      end
      else if (wr_idx_r == ccr_pkg::IDX_STATUS)
        bresp_nxt = ccr_pkg::RESP_OKAY;
      else
        bresp_nxt = ccr_pkg::RESP_SLVERR;
    end
    awready_nxt = !aw_held_nxt && !bvalid_nxt;
    wready_nxt  = !w_held_nxt && !bvalid_nxt;
  end

  always_comb
  begin
    rd_idx     = s_axi_araddr[11:2];
    rvalid_nxt = s_axi_rvalid;
    rdata_nxt  = s_axi_rdata;
    rresp_nxt  = s_axi_rresp;
    if (s_axi_rvalid && s_axi_rready)
      rvalid_nxt = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = ccr_pkg::RESP_OKAY;
      rdata_nxt  = 32'h0;
      if (rd_idx == ccr_pkg::IDX_SEL_AUX)
        rdata_nxt[7:0] = sel_reg_r[0];
      else if (rd_idx == ccr_pkg::IDX_SEL_OSC)
        rdata_nxt[7:0] = sel_reg_r[1];
      else if (rd_idx == ccr_pkg::IDX_SEL_LOOP)
        rdata_nxt[7:0] = sel_reg_r[2];
      else if (rd_idx == ccr_pkg::IDX_SLEW)
        rdata_nxt[2:0] = slew_r;
      else if (rd_idx == ccr_pkg::IDX_STATUS)
      begin
        rdata_nxt[ccr_pkg::ST_HOLD_BIT] = aux_holdover;
        rdata_nxt[ccr_pkg::ST_SLEW_BIT] = (slew_r != 3'h0);
      end
      else
        rresp_nxt = ccr_pkg::RESP_SLVERR;
    end
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      wr_idx_r      <= 10'h0;
      wdata_r       <= 32'h0;
      wstrb0_r      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= ccr_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= ccr_pkg::RESP_OKAY;
      for (int r = 0; r < 3; r++)
        sel_reg_r[r] <= ccr_pkg::SEL_RESET;
      slew_r        <= ccr_pkg::SLEW_RESET;
    end
    else
    begin
      aw_held_r     <= aw_held_nxt;
      w_held_r      <= w_held_nxt;
      wr_idx_r      <= wr_idx_nxt;
      wdata_r       <= wdata_nxt;
      wstrb0_r      <= wstrb0_nxt;
      s_axi_awready <= awready_nxt;
      s_axi_wready  <= wready_nxt;
      s_axi_bvalid  <= bvalid_nxt;
      s_axi_bresp   <= bresp_nxt;
      s_axi_arready <= arready_nxt;
      s_axi_rvalid  <= rvalid_nxt;
      s_axi_rdata   <= rdata_nxt;
      s_axi_rresp   <= rresp_nxt;
      for (int r = 0; r < 3; r++)
        sel_reg_r[r] <= sel_reg_nxt[r];
      slew_r        <= slew_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_wr_osc_five;
    wr_en && wr_idx_r == ccr_pkg::IDX_SEL_OSC && wstrb0_r &&
      wdata_r[2:0] == 3'h5;
  endsequence

  sequence s_rd_aux;
    s_axi_arvalid && s_axi_arready && rd_idx == ccr_pkg::IDX_SEL_AUX;
  endsequence

  AST_OSC0_FIVE: assert property (s_wr_osc_five ##1 1'b1 |=>
    dest_r.aux_osc0 == $past(limited[5]))
    else $error("oscillator 0 did not take composite five");

  AST_PACK_READ: assert property (s_rd_aux |=>
    s_axi_rvalid && s_axi_rdata == {24'h0, $past(sel_reg_r[0])})
    else $error("selector register read back wrong");

  AST_ZERO_ROUTE: assert property ((sel[0] == 3'h0) |=>
    dest_r.aux_loop == 32'h0)
    else $error("index zero gave nonzero compensation");

  AST_TRACK: assert property ((sel[5] != 3'h0) |=>
    dest_r.main_loop_channel_1 == $past(limited[sel[5]]))
    else $error("channel 1 not tracking its composite");

  AST_ROUTE_CONV: assert property (1'b1 |=>
    dest_r.converters == $past(limited[sel[1]]))
    else $error("converter group routed wrong composite");

  AST_NO_LIMIT: assert property ((slew_r == 3'h0) |=>
    limited[7] == $past(target[7]))
    else $error("code zero still limited the rate");

  AST_HOLD_FREEZE: assert property (aux_holdover |=> $stable(f3_r))
    else $error("method three factor moved in holdover");

  AST_GLOBAL_STEP: assert property ((slew_r == 3'h3 && !tick) |=>
    $stable(limited[1]) && $stable(limited[6]))
    else $error("composite moved between ticks");

  AST_RESET_ZERO: assert property (@(posedge aclk) disable iff (1'b0)
    !aresetn |=> sel_reg_r[0] == 8'h0 && sel_reg_r[1] == 8'h0 &&
      sel_reg_r[2] == 8'h0)
    else $error("selectors not zero after reset");

endmodule // ccr_router
`default_nettype wire

/* verification/ccr_comp_sources.sv */
`timescale 1ns/1ps
`default_nettype none
module ccr_comp_sources
(
  // Clock and reset
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  // Commands from the bench
  input  wire logic                     load,
  input  wire ccr_pkg::ccr_factors_type next_factors,
  input  wire logic                     next_hold,
  // Factors toward the router
  output var ccr_pkg::ccr_factors_type  factors,
  output var logic                      aux_holdover
);
  // Method engines settle to unity until the bench commands a factor
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      factors      <= {3{ccr_pkg::FACTOR_ONE}};
      aux_holdover <= 1'b0;
    end
    else if (load)
    begin
      factors      <= next_factors;
      aux_holdover <= next_hold;
    end
  end
endmodule // ccr_comp_sources
`default_nettype wire

/* verification/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam longint TICK = 8;
  logic aclk, aresetn, load, next_hold, aux_holdover;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, prev, cur, w;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  ccr_pkg::ccr_factors_type factors, next_factors;
  ccr_pkg::ccr_dest_type dest;
  logic [2:0] sel [6];
  logic [31:0] f [3];
  logic bad;
  int seed = 40;
  int err_count, check_count;

  ccr_router #(.SLEW_TICK(TICK)) u_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .factors(factors),
    .aux_holdover(aux_holdover), .dest_r(dest));

  ccr_comp_sources u_src (.aclk(aclk), .aresetn(aresetn), .load(load),
    .next_factors(next_factors), .next_hold(next_hold),
    .factors(factors), .aux_holdover(aux_holdover));

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task summarize;
    $display("errors=%0d checks=%0d", err_count, check_count);
    if (err_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (30000) @(posedge aclk);
    err_count++;
    summarize;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Product of the method factors picked by the index bits
  function automatic logic [31:0] comp(input logic [2:0] x);
    logic [63:0] p;
    p = 64'h4000_0000;
    for (int m = 0; m < 3; m++)
      if (x[m])
        p = (p * f[m]) >> 30;
    return (x == 3'h0) ? 32'h0 : p[31:0];
  endfunction

  // Values with few fraction bits keep every product exact
  function automatic logic [31:0] rf();
    logic [31:0] r;
    r = $random(seed);
    return {1'b0, 2'b10, r[1:0], 27'h0};
  endfunction

  function automatic logic [31:0] dst(input int i);
    return dest[(5-i)*32 +: 32];
  endfunction

  function automatic logic [11:0] ad(input logic [9:0] idx);
    return {idx, 2'b00};
  endfunction

  task axi_wr(input logic [11:0] a, input logic [31:0] d,
              input logic [3:0] s, output logic [1:0] r);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done  = 1'b0;
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_wvalid  <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready === 1'b1)
      begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready === 1'b1)
      begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task axi_rd(input logic [11:0] a, output logic [31:0] d,
              output logic [1:0] r);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    // Rready stays up, so back-to-back reads never drive it twice at once
  endtask

  task set_f(input logic h, input int n);
    next_factors <= {f[0], f[1], f[2]};
    next_hold    <= h;
    load         <= 1'b1;
    @(posedge aclk);
    load <= 1'b0;
    repeat (n) @(posedge aclk);
  endtask

  task chk_all;
    for (int i = 0; i < 6; i++)
      chk(dst(i), comp(sel[i]));
  endtask

  // Writes the three selector words and reads each one back
  task wr_sel;
    for (int r = 0; r < 3; r++)
    begin
      w = {25'h0, sel[2*r+1], 1'b0, sel[2*r]};
      axi_wr(ad(ccr_pkg::IDX_SEL_AUX + 10'(r)), w, 4'hf, resp);
      chk({30'h0, resp}, {30'h0, ccr_pkg::RESP_OKAY});
      axi_rd(ad(ccr_pkg::IDX_SEL_AUX + 10'(r)), rd, resp);
      chk(rd, w);
    end
    repeat (2) @(posedge aclk);
  endtask

  initial
  begin
    {aresetn, load, next_hold, next_factors} = '0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    for (int r = 0; r < 4; r++)
    begin
      axi_rd(ad(ccr_pkg::IDX_SEL_AUX + 10'(r)), rd, resp);
      chk(rd, 32'h0);
    end
    for (int i = 0; i < 6; i++)
      chk(dst(i), 32'h0);
    // ----------------------------------------------------------------
    // Unmapped places and a write without its byte lane
    // ----------------------------------------------------------------
    axi_wr(ad(10'h284), 32'h0000_00ff, 4'hf, resp);
    chk({30'h0, resp}, {30'h0, ccr_pkg::RESP_SLVERR});
    axi_rd(ad(10'h000), rd, resp);
    chk({30'h0, resp}, {30'h0, ccr_pkg::RESP_SLVERR});
    chk(rd, 32'h0);
    for (int m = 0; m < 3; m++)
      f[m] = rf();
    set_f(1'b0, 4);
    sel = '{3'h0, 3'h0, 3'h5, 3'h0, 3'h0, 3'h0};
    axi_wr(ad(ccr_pkg::IDX_SEL_OSC), 32'h0000_0005, 4'hf, resp);
    repeat (2) @(posedge aclk);
    chk(dst(2), comp(3'h5));
    axi_wr(ad(ccr_pkg::IDX_SEL_OSC), 32'h0000_0077, 4'he, resp);
    chk({30'h0, resp}, {30'h0, ccr_pkg::RESP_OKAY});
    axi_rd(ad(ccr_pkg::IDX_SEL_OSC), rd, resp);
    chk(rd, 32'h0000_0005);
    // ----------------------------------------------------------------
    // Random routing, then factors moving under fixed routing
    // ----------------------------------------------------------------
    for (int k = 0; k < 16; k++)
    begin
      sel[0] = 3'($random(seed)) & 3'h3;
      sel[1] = 3'($random(seed));
      sel[2] = sel[1];
      sel[3] = 3'($random(seed));
      sel[4] = 3'($random(seed)) & 3'h5;
      sel[5] = 3'(k);
      wr_sel;
      chk_all;
      for (int m = 0; m < 3; m++)
        f[m] = rf();
      set_f(1'b0, 4);
      chk_all;
    end
    // ----------------------------------------------------------------
    // Holdover freezes the third method only
    // ----------------------------------------------------------------
    sel = '{3'h1, 3'h0, 3'h0, 3'h4, 3'h0, 3'h7};
    wr_sel;
    set_f(1'b1, 2);
    w = f[2];
    f[2] = f[2] ^ 32'h0800_0000;
    f[0] = rf();
    set_f(1'b1, 4);
    cur = f[2];
    f[2] = w;
    chk(dst(3), comp(3'h4));
    chk(dst(5), comp(3'h7));
    axi_rd(ad(ccr_pkg::IDX_STATUS), rd, resp);
    chk({31'h0, rd[0]}, 32'h1);
    f[2] = cur;
    set_f(1'b0, 4);
    chk_all;
    // ----------------------------------------------------------------
    // Slew limiting for every code
    // ----------------------------------------------------------------
    for (int c = 1; c < 8; c++)
    begin
      axi_wr(ad(ccr_pkg::IDX_SLEW), 32'h0, 4'hf, resp);
      f[0] = 32'h4000_0000;
      set_f(1'b0, 4);
      chk(dst(0), f[0]);
      axi_wr(ad(ccr_pkg::IDX_SLEW), 32'(c), 4'hf, resp);
      axi_rd(ad(ccr_pkg::IDX_SLEW), rd, resp);
      chk(rd, 32'(c));
      axi_rd(ad(ccr_pkg::IDX_STATUS), rd, resp);
      chk(rd, 32'h2);
      f[0] = 32'h4000_0000 + 32'(20 << (c - 1));
      set_f(1'b0, 0);
      bad  = 1'b0;
      prev = dst(0);
      for (int n = 0; n < 64; n++)
      begin
        @(posedge aclk);
        cur = dst(0);
        if (cur - prev > 32'(1 << (c - 1)))
          bad = 1'b1;
        prev = cur;
      end
      if (cur >= f[0] || cur - 32'h4000_0000 < 32'(6 << (c - 1)))
        bad = 1'b1;
      chk({31'h0, bad}, 32'h0);
      chk(dst(1), 32'h0);
      repeat (21 * TICK + 8) @(posedge aclk);
      chk(dst(0), f[0]);
    end
    summarize;
  end
endmodule // tb
`default_nettype wire
